// [crc8_calc.sv]
/*
 * Combinational 8-bit CRC over N serial bits, MSB first, each bit shifted
 * into the LSB of the shift register. Assumes seed and data are static.
 */
`timescale 1ns/100ps
module crc8_calc
    import spi_stat_pkg::*;
#(
    parameter int N = 1
) (
    // Inputs
    input  wire logic [7:0]   seed,
    input  wire logic [N-1:0] data,
    // Result
    output logic      [7:0]   crc
);
    logic [7:0] chain [0:N];

    assign chain[0] = seed;

    // ======================================================================
    // One step per bit
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_step
            assign chain[i+1] = {chain[i][6:0], data[N-1-i]}
                                ^ ({8{chain[i][7]}} & CRC_POLY);
        end
    endgenerate

    assign crc = chain[N];
endmodule

// [spi_host_model.sv]
/*
 * Host model for the serial port: drives clock, select and command data,
 * and captures the answer. Assumes the bench calls frame() between frames.
 */
`timescale 1ns/100ps
module spi_host_model (
    // Link
    output logic      sclk,
    output logic      ss_n,
    output logic      mosi,
    input  wire logic miso
);
    // ==========
    // Frame
    initial begin
        sclk = 1'b0;
        ss_n = 1'b0;
        mosi = 1'b0;
        #1 ss_n = 1'b1;                     // Edge presets the frame flag
    end

    // Clock stands still outside frames unless hs or he is set
    task automatic frame(input logic [31:0] w, input int n,
                         input logic hs, he, output logic [31:0] r);
        r = '0;
        sclk = hs;                          // Level hs at select fall
        #7 ss_n = 1'b0;
        #40 sclk = 1'b0;
        for (int i = 0; i < n; i++) begin   // Exact edge count
            mosi = w[31-i];
            #16 sclk = 1'b1;
            #16 r[31-i] = miso;
            sclk = 1'b0;
        end
        sclk = he;                          // Level he at select rise
        #16 ss_n = 1'b1;
        #8 sclk = 1'b0;
        mosi = ~mosi;                       // Released line shows no bit
    endtask
endmodule

// [spi_stat_pkg.sv]
/*
 * Constants for the serial port status and error detection block: response
 * layout, status codes, register offsets, field positions and CRC figures.
 * Assumes a 32-bit command and response frame, MSB first.
 */
// ==========================================================================
// Operation
// - Detailed status of a response is captured at the select deassert edge.
// - Common-mode or temperature fault gives detailed status code 00.
// - User OTP, user RW or factory OTP memory error gives code 01.
// - Test mode, supply fault or device reset flag gives code 10.
// - Clock rising edge count during select other than 16 is an error.
// - Command CRC mismatch on the input line is a serial port error.
// - Write to non-lock register while init lock set is an error.
// - Serial port error answers basic status internal error, detailed 11.
// - Any output bit differing from intended bit sets the mismatch flag.
// - Sensor request in a mismatched transfer is dropped, error answered.
// - Register write in a mismatched transfer is done, error answered.
// - Register read in a mismatched transfer is dropped, error answered.
// - Factory and user OTP blocks report their own verification errors.
// - Basic status code 11 means internal error, detail in status field.
// - Command CRC is 8 bits over 32 bits, MSB first, given poly.
package spi_stat_pkg;

    // ======================================================================
    // Frame and CRC
    localparam int          FRAME_BITS  = 32;
    localparam int          CNT_W       = 6;
    localparam int          IDX_W       = 5;
    localparam logic [4:0]  IDX_FIRST   = 5'h1E;
    localparam logic [7:0]  CRC_POLY    = 8'h2F;
    localparam logic [7:0]  CRC_SEED    = 8'hFF;
    localparam logic [7:0]  CRC_ZERO    = 8'h00;

    // ======================================================================
    // Command word fields
    localparam int          CMD_HI      = 31;
    localparam int          CMD_LO      = 28;
    localparam int          ADDR_HI     = 23;
    localparam int          ADDR_LO     = 16;
    localparam int          WDAT_HI     = 15;
    localparam int          WDAT_LO     = 8;
    localparam logic [3:0]  CMD_READ    = 4'h1;
    localparam logic [3:0]  CMD_WRITE   = 4'h2;
    localparam logic [3:0]  CMD_SENSOR  = 4'h4;

    // ======================================================================
    // Status codes
    localparam logic [1:0]  BS_INIT     = 2'h0;
    localparam logic [1:0]  BS_NORMAL   = 2'h1;
    localparam logic [1:0]  BS_SELFTEST = 2'h2;
    localparam logic [1:0]  BS_ERROR    = 2'h3;
    localparam logic [1:0]  DS_CM_TEMP  = 2'h0;
    localparam logic [1:0]  DS_MEMORY   = 2'h1;
    localparam logic [1:0]  DS_TEST_SUP = 2'h2;
    localparam logic [1:0]  DS_SPI_ERR  = 2'h3;
    localparam logic [31:0] RESP_RESET  = 32'h0000_0000;
    localparam logic [19:0] DATA_NONE   = 20'h0_0000;
    localparam logic [3:0]  RD_PAD      = 4'h0;

    // ======================================================================
    // Register offsets
    localparam logic [7:0]  ADDR_FRAME_CNT  = 8'h00;
    localparam logic [7:0]  ADDR_SUMMARY    = 8'h01;
    localparam logic [7:0]  ADDR_SUPPLY     = 8'h02;
    localparam logic [7:0]  ADDR_MEMORY     = 8'h03;
    localparam logic [7:0]  ADDR_OUT_CHECK  = 8'h04;
    localparam logic [7:0]  ADDR_TEMP       = 8'h0E;
    localparam logic [7:0]  ADDR_LOCK_WRITE = 8'h10;
    localparam logic [7:0]  SUPPLY_MASK     = 8'h8F;
    localparam logic [7:0]  REG_ZERO        = 8'h00;
    localparam logic [7:0]  CNT_ONE         = 8'h01;

endpackage

// [spi_status_error_detect.sv]
/*
 * Status and error detection for the serial slave port: link receive on the
 * serial clock, frame checks, response build and output readback check on
 * the system clock. Assumes the host stops the clock low around select.
 */
`timescale 1ns/100ps
module spi_status_error_detect
    import spi_stat_pkg::*;
#(
    parameter logic [5:0] EDGE_COUNT = 6'd16
) (
    // System
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Serial link
    input  wire logic        sclk,
    input  wire logic        ss_n,
    input  wire logic        mosi,
    input  wire logic        miso_rb,
    output logic             miso_o,
    output logic             miso_oe,
    // Device status sources
    input  wire logic        common_mode_fault,
    input  wire logic        temp_fault,
    input  wire logic        user_otp_err,
    input  wire logic        user_rw_err,
    input  wire logic        factory_otp_err,
    input  wire logic        user_write_active,
    input  wire logic        test_active_flag,
    input  wire logic        device_reset_flag,
    input  wire logic        self_test_active,
    input  wire logic        init_done_lock,
    input  wire logic [7:0]  supply_flags,
    input  wire logic [7:0]  temperature_value,
    input  wire logic [19:0] sensor_data,
    // Command results
    output logic             wr_strobe,
    output logic [7:0]       wr_addr,
    output logic [7:0]       wr_data,
    output logic             sensor_req,
    output logic [1:0]       basic_status,
    output logic [1:0]       detailed_status,
    output logic             out_mismatch
);
    // ======================================================================
    // Link domain: shift, edge count and command CRC
    logic             lk_first_q;
    logic [31:0]      lk_rx_q;
    logic [CNT_W-1:0] lk_cnt_q;
    logic [7:0]       lk_crc_q;
    logic [7:0]       lk_crc_d;
    logic [7:0]       lk_seed;

    // Select high rearms the frame; values stay for the end capture
    always_ff @(posedge sclk or posedge ss_n) begin
        if (ss_n) begin
            lk_first_q <= 1'b1;
        end else begin
            lk_first_q <= 1'b0;
        end
    end

    assign lk_seed = lk_first_q ? CRC_SEED : lk_crc_q;

    crc8_calc #(.N(1)) u_rx_crc (
        .seed (lk_seed),
        .data (mosi),
        .crc  (lk_crc_d)
    );

    always_ff @(posedge sclk) begin
        lk_rx_q  <= {lk_rx_q[30:0], mosi};
        lk_crc_q <= lk_crc_d;
        if (lk_first_q) begin
            lk_cnt_q <= CNT_W'(1);
        end else if (lk_cnt_q != '1) begin
            lk_cnt_q <= lk_cnt_q + CNT_W'(1);
        end
    end

    // ======================================================================
    // Pin synchronisers
    logic ss_s1_q, ss_s2_q, ss_s3_q;
    logic sck_s1_q, sck_s2_q, sck_s3_q;
    logic rb_s1_q, rb_s2_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ss_s1_q  <= 1'b1;
            ss_s2_q  <= 1'b1;
            ss_s3_q  <= 1'b1;
            sck_s1_q <= 1'b0;
            sck_s2_q <= 1'b0;
            sck_s3_q <= 1'b0;
            rb_s1_q  <= 1'b0;
            rb_s2_q  <= 1'b0;
        end else begin
            ss_s1_q  <= ss_n;
            ss_s2_q  <= ss_s1_q;
            ss_s3_q  <= ss_s2_q;
            sck_s1_q <= sclk;
            sck_s2_q <= sck_s1_q;
            sck_s3_q <= sck_s2_q;
            rb_s1_q  <= miso_rb;
            rb_s2_q  <= rb_s1_q;
        end
    end

    wire sel_fall = ss_s3_q & ~ss_s2_q;
    wire sel_rise = ~ss_s3_q & ss_s2_q;
    wire sck_fall = sck_s3_q & ~sck_s2_q;

    // ======================================================================
    // Frame end decode; link words are static once select has risen
    logic        active_q;
    logic        clk_bad_start_q;
    logic        mm_frame_q;
    logic        miso_q;
    logic [31:0] resp_q;

    wire [3:0] cmd      = lk_rx_q[CMD_HI:CMD_LO];
    wire [7:0] addr     = lk_rx_q[ADDR_HI:ADDR_LO];
    wire [7:0] wdat     = lk_rx_q[WDAT_HI:WDAT_LO];
    wire       is_read  = cmd == CMD_READ;
    wire       is_write = cmd == CMD_WRITE;
    wire       is_sens  = cmd == CMD_SENSOR;

    wire clk_bad  = clk_bad_start_q | sck_s2_q;
    wire cnt_bad  = lk_cnt_q != EDGE_COUNT;
    wire crc_bad  = lk_crc_q != CRC_ZERO;
    wire lock_bad = is_write & init_done_lock
                    & (addr != ADDR_LOCK_WRITE);
    wire spi_err  = clk_bad | cnt_bad | crc_bad | lock_bad;
    wire mm_now   = active_q & (rb_s2_q != miso_q);
    wire mm_all   = mm_frame_q | mm_now;
    wire err_next = spi_err | mm_all;

    wire wr_ok    = is_write & ~spi_err;
    wire rd_ok    = is_read & ~err_next;
    wire sens_ok  = is_sens & ~err_next;

    // ======================================================================
    // Status registers
    logic       miso_err_q;
    logic       comm_err_q;
    logic [7:0] frame_cnt_q;

    wire fault_cm  = common_mode_fault | temp_fault;
    wire fault_mem = user_otp_err | user_rw_err
                     | factory_otp_err;
    wire [7:0] sup_reg = supply_flags & SUPPLY_MASK;
    wire fault_ts  = test_active_flag | (|sup_reg)
                     | device_reset_flag;

    wire [7:0] sum_reg = {common_mode_fault, 1'b0, comm_err_q,
                          fault_mem | temp_fault, |sup_reg,
                          test_active_flag, device_reset_flag,
                          ~init_done_lock};
    wire [7:0] mem_reg = {factory_otp_err, user_otp_err, user_rw_err,
                          user_write_active, 1'b0, temp_fault,
                          2'b00};
    wire [7:0] oc_reg  = {miso_err_q, 7'h00};
    wire [7:0] rd_data = (addr == ADDR_FRAME_CNT) ? frame_cnt_q :
                         (addr == ADDR_SUMMARY)   ? sum_reg :
                         (addr == ADDR_SUPPLY)    ? sup_reg :
                         (addr == ADDR_MEMORY)    ? mem_reg :
                         (addr == ADDR_OUT_CHECK) ? oc_reg :
                         (addr == ADDR_TEMP)      ? temperature_value :
                                                    REG_ZERO;

    // ======================================================================
    // Response build; errors outrank faults, fault codes ordered 10, 01, 00
    wire any_err = err_next | miso_err_q;
    wire [1:0] ds_d = any_err   ? DS_SPI_ERR :
                      fault_ts  ? DS_TEST_SUP :
                      fault_mem ? DS_MEMORY :
                                  DS_CM_TEMP;
    wire [1:0] bs_d = (any_err | fault_ts | fault_mem | fault_cm)
                                         ? BS_ERROR :
                      self_test_active   ? BS_SELFTEST :
                      ~init_done_lock    ? BS_INIT :
                                           BS_NORMAL;
    wire [19:0] dat_d = sens_ok ? sensor_data :
                        rd_ok   ? {RD_PAD, addr, rd_data} :
                                  DATA_NONE;
    wire [23:0] body_d = {bs_d, ds_d, dat_d};
    wire [7:0]  tx_crc;

    crc8_calc #(.N(FRAME_BITS)) u_tx_crc (
        .seed (CRC_SEED),
        .data ({body_d, CRC_ZERO}),
        .crc  (tx_crc)
    );

    wire oc_read_clr = rd_ok & (addr == ADDR_OUT_CHECK);
    wire miso_set    = sel_rise & mm_all;

    // Status is frozen at the select deassert edge, sent in the next frame
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            resp_q          <= RESP_RESET;
            basic_status    <= BS_INIT;
            detailed_status <= DS_CM_TEMP;
            frame_cnt_q     <= REG_ZERO;
            comm_err_q      <= 1'b0;
        end else if (sel_rise) begin
            resp_q          <= {body_d, tx_crc};
            basic_status    <= bs_d;
            detailed_status <= ds_d;
            frame_cnt_q     <= frame_cnt_q + CNT_ONE;
            comm_err_q      <= err_next;
        end
    end

    // Set wins over the clear done by reading the register
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            miso_err_q <= 1'b0;
        end else begin
            miso_err_q <= miso_set
                          | (miso_err_q & ~(sel_rise & oc_read_clr));
        end
    end

    // ======================================================================
    // Command strobes
    logic       wr_strobe_q;
    logic       sensor_req_q;
    logic [7:0] wr_addr_q;
    logic [7:0] wr_data_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wr_strobe_q  <= 1'b0;
            sensor_req_q <= 1'b0;
            wr_addr_q    <= REG_ZERO;
            wr_data_q    <= REG_ZERO;
        end else begin
            wr_strobe_q  <= sel_rise & wr_ok;
            sensor_req_q <= sel_rise & sens_ok;
            if (sel_rise & wr_ok) begin
                wr_addr_q <= addr;
                wr_data_q <= wdat;
            end
        end
    end

    // ======================================================================
    // Output launch and readback compare; the pad runs off the system clock
    // so the first bit stands before the host's first rising edge
    logic [IDX_W-1:0] idx_q;
    logic             oe_q;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            active_q        <= 1'b0;
            oe_q            <= 1'b0;
            miso_q          <= 1'b0;
            idx_q           <= '0;
            mm_frame_q      <= 1'b0;
            clk_bad_start_q <= 1'b0;
        end else if (sel_fall) begin
            active_q        <= 1'b1;
            oe_q            <= 1'b1;
            miso_q          <= resp_q[FRAME_BITS-1];
            idx_q           <= IDX_FIRST;
            mm_frame_q      <= 1'b0;
            clk_bad_start_q <= sck_s2_q;
        end else if (sel_rise) begin
            active_q <= 1'b0;
            oe_q     <= 1'b0;
        end else if (sck_fall & active_q) begin
            mm_frame_q <= mm_frame_q | mm_now;
            miso_q     <= resp_q[idx_q];
            if (idx_q != '0) begin
                idx_q <= idx_q - IDX_W'(1);
            end
        end
    end

    assign miso_o       = miso_q;
    assign miso_oe      = oe_q;
    assign wr_strobe    = wr_strobe_q;
    assign wr_addr      = wr_addr_q;
    assign wr_data      = wr_data_q;
    assign sensor_req   = sensor_req_q;
    assign out_mismatch = miso_err_q;

    // ======================================================================
    // Checks
    wire resp_msb = resp_q[FRAME_BITS-1];
    wire fault_any = fault_ts | fault_mem | fault_cm;

    sequence s_frame_end_err;
        sel_rise && err_next;
    endsequence

    sequence s_frame_start;
        sel_fall;
    endsequence

    AST_CLK_START: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_fall && sck_s2_q |=> clk_bad_start_q)
        else $error("Clock high at select assert not caught");
    AST_CNT_ERR: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && cnt_bad |=> resp_q[31:28] == {BS_ERROR, DS_SPI_ERR})
        else $error("Edge count error not answered");
    AST_CRC_ERR: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && crc_bad |=> detailed_status == DS_SPI_ERR)
        else $error("CRC error not answered");
    AST_LOCK: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && lock_bad |=> !wr_strobe && detailed_status == DS_SPI_ERR)
        else $error("Locked write was performed");
    AST_ERR_RESP: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_frame_end_err |=> (basic_status == BS_ERROR
                             && detailed_status == DS_SPI_ERR) [*2])
        else $error("Error response not held");
    AST_MM_FLAG: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && mm_all |=> out_mismatch)
        else $error("Mismatch flag not set");
    AST_SENS_DROP: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && is_sens && mm_all |=> !sensor_req
                                          && resp_q[27:8] == DATA_NONE)
        else $error("Sensor request not dropped");
    AST_WR_KEEP: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && wr_ok && mm_all |=> wr_strobe ##1 !wr_strobe)
        else $error("Write not done once");
    AST_RD_DROP: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && is_read && mm_all |=> resp_q[27:8] == DATA_NONE)
        else $error("Read not dropped");
    AST_MEM_CODE: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && !any_err && fault_mem && !fault_ts
        |=> detailed_status == DS_MEMORY)
        else $error("Memory code wrong");
    AST_TS_CODE: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && !any_err && fault_ts |=> detailed_status == DS_TEST_SUP)
        else $error("Test or supply code wrong");
    AST_CM_CODE: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && !any_err && fault_cm && !fault_ts && !fault_mem
        |=> detailed_status == DS_CM_TEMP && basic_status == BS_ERROR)
        else $error("Common-mode code wrong");
    AST_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !sel_rise |=> $stable(detailed_status))
        else $error("Status moved outside select edge");
    AST_BS_OK: assert property (@(posedge clk_sys) disable iff (!rstn)
        sel_rise && !any_err && !fault_any |=> basic_status != BS_ERROR)
        else $error("Basic status error without cause");
    AST_LAUNCH: assert property (@(posedge clk_sys) disable iff (!rstn)
        s_frame_start |=> miso_oe && miso_o == $past(resp_msb))
        else $error("First bit not launched");
endmodule

// [test_spi_status_error_detect.sv]
/*
 * Self-checking bench for the serial status and error block.
 * Assumes spi_host_model as the host and a 32-edge frame setting.
 */
`timescale 1ns/100ps
module test_spi_status_error_detect;
    import spi_stat_pkg::*;
    // ==========
    // Signals
    logic       clk_sys, rstn, sclk, ss_n, mosi, pad, miso_o, miso_oe;
    logic       flip, wr_strobe, sensor_req, out_mismatch;
    logic [9:0] flg;
    logic [7:0] sup, wr_addr, wr_data;
    logic [1:0] basic_status, detailed_status;
    int         err_count = 0, checked = 0, wr_n = 0, sn_n = 0;

    // Pad pulled up while released; flip corrupts the driven level
    assign pad = miso_oe ? miso_o ^ flip : 1'b1;

    spi_status_error_detect #(.EDGE_COUNT(6'h20)) DUT (
        .clk_sys(clk_sys), .rstn(rstn), .sclk(sclk), .ss_n(ss_n),
        .mosi(mosi), .miso_rb(pad), .miso_o(miso_o), .miso_oe(miso_oe),
        .common_mode_fault(flg[9]), .temp_fault(flg[8]),
        .user_otp_err(flg[7]), .user_rw_err(flg[6]),
        .factory_otp_err(flg[5]), .test_active_flag(flg[4]),
        .device_reset_flag(flg[3]), .user_write_active(flg[2]),
        .self_test_active(flg[1]), .init_done_lock(flg[0]),
        .supply_flags(sup), .temperature_value(8'h3C),
        .sensor_data(20'hA_5C3F), .wr_strobe(wr_strobe),
        .wr_addr(wr_addr), .wr_data(wr_data), .sensor_req(sensor_req),
        .basic_status(basic_status), .detailed_status(detailed_status),
        .out_mismatch(out_mismatch)
    );
    spi_host_model HOST (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso(pad));

    // ==========
    // Clock and pulse counters
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        if (wr_strobe === 1'b1) wr_n++;
        if (sensor_req === 1'b1) sn_n++;
    end

    // ==========
    // Helpers
    function automatic logic [31:0] mk(input logic [23:0] b);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 31; i >= 0; i--)
            c = {c[6:0], i > 7 ? b[i-8] : 1'b0} ^ (c[7] ? CRC_POLY : 8'h00);
        return {b, c};
    endfunction
    task automatic check(input string n, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, s);
            err_count++;
        end
    endtask
    task automatic fr(input logic [31:0] w, input int n,
                      input logic hs, he, output logic [31:0] r);
        HOST.frame(w, n, hs, he, r);
        repeat (8) @(posedge clk_sys);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ==========
    // Scenarios
    task automatic t_write();
        logic [31:0] r;
        check("basic_rst", 32'(basic_status), 32'(BS_INIT));
        check("mis_rst", 32'(out_mismatch), 32'h0);
        fr(mk({CMD_WRITE, 4'h0, 8'h20, 8'h5A}), 32, 1'b0, 1'b0, r);
        check("resp0", r, RESP_RESET);
        check("oe_idle", 32'(miso_oe), 32'h0);
        check("wr", 32'(wr_n), 32'h1);
        check("waddr", 32'(wr_addr), 32'h20);
        check("wdata", 32'(wr_data), 32'h5A);
        $display("write test done");
    endtask
    task automatic t_detail();
        logic [31:0] r;
        logic [1:0]  e;
        for (int i = 0; i < 8; i++) begin
            e = i < 2 ? DS_CM_TEMP : i < 5 ? DS_MEMORY : DS_TEST_SUP;
            flg <= i < 7 ? 10'h200 >> i : 10'h000;
            sup <= i == 7 ? 8'h01 : 8'h00;
            repeat (4) @(posedge clk_sys);
            fr(mk({CMD_SENSOR, 20'h0_0000}), 32, 1'b0, 1'b0, r);
            flg <= '0;
            sup <= '0;
            check("detail", 32'(detailed_status), 32'(e));
            check("basic", 32'(basic_status), 32'(BS_ERROR));
            fr(mk({CMD_READ, 4'h0, ADDR_FRAME_CNT, 8'h00}), 32, 1'b0, 1'b0, r);
            check("resp_ds", 32'(r[29:28]), 32'(e));
        end
        $display("detail test done");
    endtask
    task automatic t_errors();
        logic [31:0] r, w;
        int          w0;
        flg <= 10'h001;
        for (int k = 0; k < 5; k++) begin
            w = mk({CMD_WRITE, 4'h0, 8'h20, 8'(k)});
            w0 = wr_n;
            fr(k == 3 ? w ^ 32'h1 : w, k == 2 ? 31 : 32, k == 0, k == 1, r);
            check("err_wr", 32'(wr_n - w0), 32'h0);
            check("err_ds", 32'(detailed_status), 32'(DS_SPI_ERR));
            check("err_bs", 32'(basic_status), 32'(BS_ERROR));
        end
        w0 = wr_n;
        fr(mk({CMD_WRITE, 4'h0, ADDR_LOCK_WRITE, 8'h80}), 32, 1'b0, 1'b0, r);
        flg <= '0;
        check("lock_wr", 32'(wr_n - w0), 32'h1);
        check("err_rsp", r, mk({BS_ERROR, DS_SPI_ERR, DATA_NONE}));
        $display("error test done");
    endtask
    task automatic t_mismatch();
        logic [31:0] r;
        int          w0, s0;
        w0 = wr_n;
        s0 = sn_n;
        flip <= 1'b1;
        fr(mk({CMD_SENSOR, 20'h0_0000}), 32, 1'b0, 1'b0, r);
        check("mis", 32'(out_mismatch), 32'h1);
        check("mis_sn", 32'(sn_n - s0), 32'h0);
        check("mis_ds", 32'(detailed_status), 32'(DS_SPI_ERR));
        fr(mk({CMD_WRITE, 4'h0, 8'h21, 8'h33}), 32, 1'b0, 1'b0, r);
        check("mis_wr", 32'(wr_n - w0), 32'h1);
        fr(mk({CMD_READ, 4'h0, ADDR_TEMP, 8'h00}), 32, 1'b0, 1'b0, r);
        flip <= 1'b0;
        fr(mk({CMD_READ, 4'h0, ADDR_OUT_CHECK, 8'h00}), 32, 1'b0, 1'b0, r);
        check("mis_rd", 32'(r[27:8]), 32'(DATA_NONE));
        fr(mk({CMD_SENSOR, 20'h0_0000}), 32, 1'b0, 1'b0, r);
        check("rd_chk", 32'(r[27:8]), 32'h0_0480);
        check("sn", 32'(sn_n - s0), 32'h1);
        fr(mk({CMD_READ, 4'h0, ADDR_FRAME_CNT, 8'h00}), 32, 1'b0, 1'b0, r);
        check("sn_dat", 32'(r[27:8]), 32'h000A_5C3F);
        $display("mismatch test done");
    endtask

    // ==========
    // Main sequence and watchdog
    initial begin
        rstn = 1'b0;
        flg = '0;
        sup = '0;
        flip = 1'b0;
        repeat (16) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (4) @(posedge clk_sys);
        t_write();
        t_detail();
        t_errors();
        t_mismatch();
        give_verdict();
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        err_count++;
        give_verdict();
    end
endmodule
